// ===== lowside_pkg.sv
// How it works
// - gate data bit one turns gate on
// - disabled driver reads stored gate data
// - enabled driver reads selected control source (gate data bit or routed source)
// - stop entry clears both gate data bits
// - registers decoded at base plus offset
// - enable bit powers driver, selected source drives
// - stop disables drivers, gates off, auto resume
// - disabled driver is fully shut down
package lowside_pkg;

  // register offsets (byte index; byte address is four times it)
  localparam logic [2:0] GATE_DATA_IDX = 3'h0;
  localparam logic [2:0] DRIVER_CONFIG_IDX = 3'h1;
  localparam logic [2:0] FACTORY_TEST_A_IDX = 3'h2;
  localparam logic [2:0] FACTORY_TEST_B_IDX = 3'h3;
  localparam logic [2:0] SPARE_SLOT_IDX = 3'h4;
  localparam logic [2:0] OPENLOAD_STATUS_IDX = 3'h5;
  localparam logic [2:0] IRQ_ENABLE_IDX = 3'h6;
  localparam logic [2:0] IRQ_FLAGS_IDX = 3'h7;

  // field positions
  localparam int DRIVER_ENABLE_LSB = 0;
  localparam int OPENLOAD_EN_LSB = 2;
  localparam int OVERCURRENT_IRQ_EN_BIT = 7;

  // reset values
  localparam logic [1:0] GATE_DATA_RST = 2'h0;
  localparam logic [3:0] DRIVER_CONFIG_RST = 4'h0;
  localparam logic [7:0] FACTORY_TEST_A_RST = 8'h03;
  localparam logic [7:0] FACTORY_TEST_B_RST = 8'h00;
  localparam logic IRQ_ENABLE_RST = 1'b0;
  localparam logic [1:0] IRQ_FLAGS_RST = 2'h0;

  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // settling time in ns and the cycles it takes at 125 MHz
  localparam int CLOCK_PERIOD_NS = 8;
  localparam int SETTLE_TIME_NS = 1000;
  localparam int SETTLE_CYCLES = (SETTLE_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;

  // bus handshake state
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_WRESP = 2'b01,
    BUS_RRESP = 2'b11
  } bus_state_t;

  // write side of axi-lite
  typedef struct packed {
    logic [31:0] awaddr;
    logic awvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic bready;
  } axi_w_req_t;

  // read side of axi-lite
  typedef struct packed {
    logic [31:0] araddr;
    logic arvalid;
    logic rready;
  } axi_r_req_t;

  // all block state
  typedef struct packed {
    logic [1:0] gate_data;
    logic [3:0] driver_config;
    logic [7:0] factory_test_a;
    logic [7:0] factory_test_b;
    logic irq_enable;
    logic [1:0] irq_flags;
    logic stop_seen;
    logic wr_busy;
    logic rd_busy;
    logic [1:0] bresp;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic aw_held;
    logic [2:0] aw_idx;
    logic aw_ok;
    logic w_held;
    logic [7:0] w_byte;
    logic w_lane;
    logic [1:0] gate_on;
  } state_t;

endpackage

// ===== lowside_driver_regs.sv
// Chosen here: the AXI4-Lite register port.
module lowside_driver_regs (
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic clock_en_i,
  // stop mode request from the system
  input wire logic stop_mode_i,
  // special (test) mode allows factory register writes
  input wire logic special_mode_i,
  // routed timer / pwm source per driver, already chosen by the routing unit
  input wire logic [1:0] routed_source_i,
  // selects gate data bit as source per driver
  input wire logic [1:0] source_is_data_i,
  // analog detection inputs
  input wire logic [1:0] openload_detect_i,
  input wire logic [1:0] overcurrent_detect_i,
  // axi-lite slave
  input wire logic [31:0] s_awaddr_i,
  input wire logic s_awvalid_i,
  output logic s_awready_o,
  input wire logic [31:0] s_wdata_i,
  input wire logic [3:0] s_wstrb_i,
  input wire logic s_wvalid_i,
  output logic s_wready_o,
  output logic [1:0] s_bresp_o,
  output logic s_bvalid_o,
  input wire logic s_bready_i,
  input wire logic [31:0] s_araddr_i,
  input wire logic s_arvalid_i,
  output logic s_arready_o,
  output logic [31:0] s_rdata_o,
  output logic [1:0] s_rresp_o,
  output logic s_rvalid_o,
  input wire logic s_rready_i,
  // driver outputs
  output logic [1:0] driver_power_o,
  output logic [1:0] gate_on_o,
  output logic [1:0] openload_detect_active_o,
  output logic irq_o
);

  lowside_pkg::state_t st_r; // registered state
  lowside_pkg::state_t st_nxt; // next state
  logic [1:0] drv_on; // driver powered this cycle
  logic [1:0] src_val; // selected control source per driver
  logic [1:0] openload_stat; // live open-load status
  logic aw_take; // address accepted now
  logic w_take; // data accepted now
  logic ar_take; // read address accepted now
  logic [7:0] rd_byte; // read mux output

  // byte index of an address; word aligned registers
  function automatic logic [2:0] reg_index(input logic [31:0] addr);
    reg_index = addr[4:2];
  endfunction

  // address hits the eight word window
  function automatic logic addr_mapped(input logic [31:0] addr);
    addr_mapped = (addr[31:5] == 27'h0000000);
  endfunction

  // driver power: enable bit and not in stop
  always_comb begin
    drv_on = st_r.driver_config[1:0] & {2{~stop_mode_i}};
  end

  // source per driver: gate data bit or routed timer/pwm
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      src_val[i] = source_is_data_i[i] ? st_r.gate_data[i] : routed_source_i[i];
    end
  end

  // open-load status only while driver powered and detection armed
  always_comb begin
    openload_stat = openload_detect_i & drv_on & st_r.driver_config[3:2];
  end

  // handshake readies: accept while no response pending
  // readies drop while the clock enable is low, so no item is shown taken and then lost
  always_comb begin
    s_awready_o = clock_en_i & ~st_r.wr_busy & ~st_r.aw_held;
    s_wready_o = clock_en_i & ~st_r.wr_busy & ~st_r.w_held;
    s_arready_o = clock_en_i & ~st_r.rd_busy;
    aw_take = s_awvalid_i & s_awready_o;
    w_take = s_wvalid_i & s_wready_o;
    ar_take = s_arvalid_i & s_arready_o;
  end

  // read mux over the byte registers
  always_comb begin
    rd_byte = 8'h00;
    case (reg_index(s_araddr_i))
      lowside_pkg::GATE_DATA_IDX: begin
        for (int i = 0; i < 2; i++) begin
          rd_byte[i] = st_r.driver_config[i] ? src_val[i] : st_r.gate_data[i];
        end
      end
      lowside_pkg::DRIVER_CONFIG_IDX: begin
        rd_byte = {4'h0, st_r.driver_config};
      end
      lowside_pkg::FACTORY_TEST_A_IDX: begin
        rd_byte = st_r.factory_test_a;
      end
      lowside_pkg::FACTORY_TEST_B_IDX: begin
        rd_byte = st_r.factory_test_b;
      end
      lowside_pkg::OPENLOAD_STATUS_IDX: begin
        rd_byte = {6'h00, openload_stat};
      end
      lowside_pkg::IRQ_ENABLE_IDX: begin
        rd_byte = {st_r.irq_enable, 7'h00};
      end
      lowside_pkg::IRQ_FLAGS_IDX: begin
        rd_byte = {6'h00, st_r.irq_flags};
      end
      default: begin
        rd_byte = 8'h00; // spare slot reads zero
      end
    endcase
  end

  // next-state logic
  always_comb begin
    logic [2:0] widx;
    logic [7:0] wb;
    logic wl;
    logic wok;
    logic do_write;
    logic [1:0] oc_set;
    st_nxt = st_r;
    do_write = 1'b0; // decided below once both halves are known
    oc_set = 2'h0; // filled from the comparators below
    widx = st_r.aw_idx;
    wb = st_r.w_byte;
    wl = st_r.w_lane;
    wok = st_r.aw_ok;
    // capture address and data in either order
    if (aw_take) begin
      widx = reg_index(s_awaddr_i);
      wok = addr_mapped(s_awaddr_i);
      st_nxt.aw_held = 1'b1;
      st_nxt.aw_idx = widx;
      st_nxt.aw_ok = wok;
    end
    if (w_take) begin
      wb = s_wdata_i[7:0];
      wl = s_wstrb_i[0];
      st_nxt.w_held = 1'b1;
      st_nxt.w_byte = wb;
      st_nxt.w_lane = wl;
    end
    do_write = (st_r.aw_held | aw_take) & (st_r.w_held | w_take) & ~st_r.wr_busy;
    // over-current events on powered drivers
    oc_set = overcurrent_detect_i & drv_on;
    st_nxt.irq_flags = st_r.irq_flags | oc_set;
    if (do_write) begin
      st_nxt.aw_held = 1'b0;
      st_nxt.w_held = 1'b0;
      st_nxt.wr_busy = 1'b1;
      st_nxt.bresp = wok ? lowside_pkg::RESP_OKAY : lowside_pkg::RESP_SLVERR;
      if (wok && wl) begin
        case (widx)
          lowside_pkg::GATE_DATA_IDX: begin
            st_nxt.gate_data = wb[1:0];
          end
          lowside_pkg::DRIVER_CONFIG_IDX: begin
            st_nxt.driver_config = wb[3:0];
          end
          lowside_pkg::FACTORY_TEST_A_IDX: begin
            if (special_mode_i) begin
              st_nxt.factory_test_a = wb;
            end
          end
          lowside_pkg::FACTORY_TEST_B_IDX: begin
            if (special_mode_i) begin
              st_nxt.factory_test_b = wb;
            end
          end
          lowside_pkg::IRQ_ENABLE_IDX: begin
            st_nxt.irq_enable = wb[lowside_pkg::OVERCURRENT_IRQ_EN_BIT];
          end
          lowside_pkg::IRQ_FLAGS_IDX: begin
            // write one clears; a new event in the same cycle wins
            st_nxt.irq_flags = (st_r.irq_flags & ~wb[1:0]) | oc_set;
          end
          default: begin
            st_nxt.bresp = lowside_pkg::RESP_OKAY; // read-only slots ignore writes
          end
        endcase
      end
    end
    // write response handshake
    if (st_r.wr_busy && s_bready_i) begin
      st_nxt.wr_busy = 1'b0;
    end
    // read request and response
    if (ar_take) begin
      st_nxt.rd_busy = 1'b1;
      st_nxt.rdata = {24'h000000, rd_byte};
      st_nxt.rresp = addr_mapped(s_araddr_i) ? lowside_pkg::RESP_OKAY : lowside_pkg::RESP_SLVERR;
      if (!addr_mapped(s_araddr_i)) begin
        st_nxt.rdata = 32'h00000000;
      end
    end else if (st_r.rd_busy && s_rready_i) begin
      st_nxt.rd_busy = 1'b0;
    end
    // stop entry clears the gate data bits
    st_nxt.stop_seen = stop_mode_i;
    if (stop_mode_i && !st_r.stop_seen) begin
      st_nxt.gate_data = lowside_pkg::GATE_DATA_RST;
    end
    // gate drive: source when powered and no over-current flag held
    for (int i = 0; i < 2; i++) begin
      st_nxt.gate_on[i] = drv_on[i] & src_val[i] & ~st_r.irq_flags[i];
    end
    if (stop_mode_i) begin
      st_nxt.gate_on = 2'h0;
    end
  end

  // state register with enable and synchronous reset
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      st_r <= '0;
      st_r.gate_data <= lowside_pkg::GATE_DATA_RST;
      st_r.driver_config <= lowside_pkg::DRIVER_CONFIG_RST;
      st_r.factory_test_a <= lowside_pkg::FACTORY_TEST_A_RST;
      st_r.factory_test_b <= lowside_pkg::FACTORY_TEST_B_RST;
      st_r.irq_enable <= lowside_pkg::IRQ_ENABLE_RST;
      st_r.irq_flags <= lowside_pkg::IRQ_FLAGS_RST;
    end else if (clock_en_i) begin
      st_r <= st_nxt;
    end
  end

  // outputs
  always_comb begin
    s_bvalid_o = st_r.wr_busy;
    s_bresp_o = st_r.bresp;
    s_rvalid_o = st_r.rd_busy;
    s_rdata_o = st_r.rdata;
    s_rresp_o = st_r.rresp;
    driver_power_o = drv_on;
    gate_on_o = st_r.gate_on;
    openload_detect_active_o = drv_on & st_r.driver_config[3:2] & ~st_r.gate_on;
    irq_o = st_r.irq_enable & (|st_r.irq_flags);
  end

endmodule

// ===== lowside_driver_regs_props.sv
module lowside_driver_regs_props (
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic clock_en_i,
  input wire logic stop_mode_i,
  input wire logic s_bvalid_o,
  input wire logic s_bready_i,
  input wire logic s_arvalid_i,
  input wire logic s_arready_o,
  input wire logic s_rvalid_o,
  input wire logic s_rready_i,
  input wire logic [31:0] s_rdata_o,
  input wire logic [1:0] driver_power_o,
  input wire logic [1:0] gate_on_o,
  input wire logic [1:0] openload_detect_active_o
);
  // one clock domain, reset cancels every attempt
  default clocking @(posedge clock_i);
  endclocking
  default disable iff (reset_i);
  // read address accepted at this edge
  sequence rd_taken;
    clock_en_i && s_arvalid_i && s_arready_o;
  endsequence
  a_stop_unpowered: assert property (stop_mode_i |-> driver_power_o == 2'h0)
    else $error("driver powered in stop");
  a_stop_gate_off: assert property ($past(stop_mode_i && clock_en_i) |-> gate_on_o == 2'h0)
    else $error("gate on in stop");
  a_gate_unpowered: assert property ($past(clock_en_i) |-> (gate_on_o & ~$past(driver_power_o)) == 2'h0)
    else $error("gate on while unpowered");
  a_detect_gated: assert property ((openload_detect_active_o & (gate_on_o | ~driver_power_o)) == 2'h0)
    else $error("detection while off or driving");
  a_read_answer: assert property (rd_taken |=> s_rvalid_o)
    else $error("read answer missing");
  a_bvalid_holds: assert property (s_bvalid_o && !s_bready_i |=> s_bvalid_o)
    else $error("write response dropped");
  a_rdata_holds: assert property (s_rvalid_o && !s_rready_i |=> s_rvalid_o && $stable(s_rdata_o))
    else $error("read data changed");
  a_upper_zero: assert property (s_rvalid_o |-> s_rdata_o[31:8] == 24'h0)
    else $error("upper read bits set");
endmodule

bind lowside_driver_regs lowside_driver_regs_props props_i (
  .clock_i(clock_i), .reset_i(reset_i), .clock_en_i(clock_en_i), .stop_mode_i(stop_mode_i),
  .s_bvalid_o(s_bvalid_o), .s_bready_i(s_bready_i), .s_arvalid_i(s_arvalid_i), .s_arready_o(s_arready_o),
  .s_rvalid_o(s_rvalid_o), .s_rready_i(s_rready_i), .s_rdata_o(s_rdata_o), .driver_power_o(driver_power_o),
  .gate_on_o(gate_on_o), .openload_detect_active_o(openload_detect_active_o)
);

// ===== tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // driven inputs
  logic clk = '0, rst = 1'h1, stop = '0, spec = '0, awv = '0, wv = '0, arv = '0, rdy = '0, cen = 1'h1;
  logic [1:0] routed = '0, src_data = '0, oc = '0, ol = '0, rs, ola;
  logic [31:0] addr = '0, wdata = '0, rd;
  // observed outputs
  logic s_awready_o, s_wready_o, s_bvalid_o, s_arready_o, s_rvalid_o, irq_o;
  logic [1:0] s_bresp_o, s_rresp_o, driver_power_o, gate_on_o;
  logic [31:0] s_rdata_o;
  int n_mismatch = 0, n_checks = 0;
  // row: byte address, byte written, byte read back, response
  typedef struct {logic [31:0] a; logic [7:0] d; logic [7:0] e; logic [1:0] r;} row_t;
  row_t rows [8] = '{'{32'h00, 8'hFF, 8'h03, 2'h0}, '{32'h04, 8'hFF, 8'h0F, 2'h0},
    '{32'h08, 8'h55, 8'h03, 2'h0}, '{32'h10, 8'hFF, 8'h00, 2'h0}, '{32'h14, 8'hFF, 8'h00, 2'h0},
    '{32'h18, 8'hFF, 8'h80, 2'h0}, '{32'h1C, 8'hFF, 8'h00, 2'h0}, '{32'h20, 8'hFF, 8'h00, 2'h2}};

  // free-running 125 MHz clock
  always #4 clk = ~clk;

  lowside_driver_regs dut (
    .clock_i(clk), .reset_i(rst), .clock_en_i(cen), .stop_mode_i(stop), .special_mode_i(spec),
    .routed_source_i(routed), .source_is_data_i(src_data), .openload_detect_i(ol),
    .overcurrent_detect_i(oc), .s_awaddr_i(addr), .s_awvalid_i(awv), .s_awready_o(s_awready_o),
    .s_wdata_i(wdata), .s_wstrb_i(4'hF), .s_wvalid_i(wv), .s_wready_o(s_wready_o), .s_bresp_o(s_bresp_o),
    .s_bvalid_o(s_bvalid_o), .s_bready_i(rdy), .s_araddr_i(addr), .s_arvalid_i(arv),
    .s_arready_o(s_arready_o), .s_rdata_o(s_rdata_o), .s_rresp_o(s_rresp_o), .s_rvalid_o(s_rvalid_o),
    .s_rready_i(rdy), .driver_power_o(driver_power_o), .gate_on_o(gate_on_o),
    .openload_detect_active_o(ola), .irq_o(irq_o)
  );

  // verdict and stop
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // compare one value
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // one axi-lite transfer; response ready is held high from the request until the answer is seen
  task automatic bus(input bit w, input logic [31:0] a, input logic [7:0] d);
    bit ta, tw, v, done;
    done = 0;
    @(posedge clk);
    addr <= a;
    wdata <= {24'h0, d};
    rdy <= 1'h1;
    if (w) begin
      awv <= 1'h1;
      wv <= 1'h1;
    end else begin
      arv <= 1'h1;
    end
    for (int i = 0; i < 40 && !done; i++) begin
      @(negedge clk);
      ta = w ? awv && s_awready_o : arv && s_arready_o;
      tw = wv && s_wready_o;
      v = w ? s_bvalid_o : s_rvalid_o;
      rd = s_rdata_o;
      rs = w ? s_bresp_o : s_rresp_o;
      @(posedge clk);
      if (ta) begin
        awv <= '0;
        arv <= '0;
      end
      if (tw) wv <= '0;
      if (v && rdy) begin
        rdy <= '0;
        done = 1;
      end
    end
    if (!done) begin
      n_mismatch++;
      end_sim();
    end
  endtask

  // main sequence
  initial begin
    repeat (10) @(posedge clk);
    rst <= '0;
    foreach (rows[i]) begin
      bus(1, rows[i].a, rows[i].d);
      chk("write resp", rows[i].r, rs);
      bus(0, rows[i].a, 8'h00);
      chk("read resp", rows[i].r, rs);
      chk("read data", rows[i].e, rd);
    end
    $display("register table done");
    // wait out the settling time before any gate turns on
    repeat (lowside_pkg::SETTLE_CYCLES) @(posedge clk);
    src_data <= 2'h3;
    bus(1, 32'h00, 8'h01);
    @(negedge clk);
    chk("gate from data", 2'h1, gate_on_o);
    chk("power", 2'h3, driver_power_o);
    @(posedge clk);
    src_data <= '0;
    routed <= 2'h2;
    bus(0, 32'h00, 8'h00);
    chk("routed read", 2'h2, rd);
    @(negedge clk);
    chk("gate from routed", 2'h2, gate_on_o);
    $display("gate sources done");
    // stop entry clears data and shuts drivers down; the routed gate is turned off first
    @(posedge clk);
    routed <= '0;
    repeat (2) @(posedge clk);
    stop <= 1'h1;
    src_data <= 2'h3;
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk("stop power", 2'h0, driver_power_o);
    chk("stop gate", 2'h0, gate_on_o);
    @(posedge clk);
    stop <= '0;
    bus(0, 32'h00, 8'h00);
    chk("data after stop", 2'h0, rd);
    @(negedge clk);
    chk("gate after stop", 2'h0, gate_on_o);
    chk("power after stop", 2'h3, driver_power_o);
    $display("stop done");
    // disabled driver keeps stored data but drives nothing
    bus(1, 32'h04, 8'h00);
    bus(1, 32'h00, 8'h03);
    @(negedge clk);
    chk("gate disabled", 2'h0, gate_on_o);
    bus(0, 32'h00, 8'h00);
    chk("stored read", 2'h3, rd);
    $display("shutdown done");
    // over-current flag: masked, unmasked, cleared
    @(posedge clk);
    src_data <= '0;
    routed <= '0;
    bus(1, 32'h04, 8'h03);
    bus(1, 32'h18, 8'h00);
    oc <= 2'h1;
    @(posedge clk);
    oc <= '0;
    bus(0, 32'h1C, 8'h00);
    chk("flag set", 8'h01, rd);
    chk("irq masked", 1'h0, irq_o);
    bus(1, 32'h18, 8'h80);
    @(negedge clk);
    chk("irq raised", 1'h1, irq_o);
    bus(1, 32'h1C, 8'h01);
    @(negedge clk);
    chk("irq cleared", 1'h0, irq_o);
    // frozen clock enable: an event while frozen is not recorded
    @(posedge clk);
    cen <= '0;
    oc <= 2'h3;
    repeat (2) @(posedge clk);
    oc <= '0;
    @(posedge clk);
    cen <= 1'h1;
    bus(0, 32'h1C, 8'h00);
    chk("frozen flags", 8'h00, rd);
    chk("frozen irq", 1'h0, irq_o);
    // open-load status needs power and detection armed
    ol <= 2'h3;
    bus(1, 32'h04, 8'h0F);
    bus(0, 32'h14, 8'h00);
    chk("openload on", 8'h03, rd);
    @(negedge clk);
    chk("detect active", 2'h3, ola);
    bus(1, 32'h04, 8'h0C);
    bus(0, 32'h14, 8'h00);
    chk("openload off", 8'h00, rd);
    ol <= '0;
    $display("interrupt done");
    // factory register writable in special mode, then a second reset
    @(posedge clk);
    spec <= 1'h1;
    bus(1, 32'h08, 8'h5A);
    bus(0, 32'h08, 8'h00);
    chk("special write", 8'h5A, rd);
    rst <= 1'h1;
    repeat (10) @(posedge clk);
    rst <= '0;
    bus(0, 32'h04, 8'h00);
    chk("config reset", 8'h00, rd);
    @(negedge clk);
    chk("gate reset", 2'h0, gate_on_o);
    $display("reset done");
    end_sim();
  end
endmodule
